/* File: src/acs_pkg.sv */
// acs_pkg: constants, types and decoders of the conversion sequencer
// assumes a single 25 MHz core clock; serial pins are sampled on it
package acs_pkg;
  typedef enum logic [1:0] {
    ACS_IDLE = 2'b00,
    ACS_SAMPLE = 2'b01,
    ACS_CONV = 2'b11
  } acs_state_t;
  typedef enum logic [1:0] {
    MODE_ONE = 2'b00,
    MODE_REP = 2'b01,
    MODE_SWP = 2'b10,
    MODE_RSW = 2'b11
  } acs_mode_t;
  localparam logic [3:0] CMD_CH_LAST = 4'h7;
  localparam logic [3:0] CMD_RD_CFG = 4'h9;
  localparam logic [3:0] CMD_WR_CFG = 4'ha;
  localparam logic [3:0] CMD_TEST_LO = 4'hb;
  localparam logic [3:0] CMD_TEST_HI = 4'hd;
  localparam logic [3:0] CMD_FIFO_RD = 4'he;
  localparam int CFG_W = 12;
  localparam logic [11:0] CFG_RST = 12'h000;
  localparam int CFG_LONG = 9;
  localparam int CFG_DIV = 8;
  localparam int CFG_MODE_LO = 5;
  localparam int CFG_SEQ_LO = 3;
  localparam int CFG_PIN = 2;
  localparam int CFG_THR_LO = 0;
  localparam logic [4:0] CMD_EDGE = 5'h04;
  localparam logic [4:0] SHORT_EDGE = 5'h10;
  localparam logic [4:0] LONG_EDGE = 5'h1c;
  localparam logic [4:0] FRAME_EDGE = 5'h10;
  localparam logic [4:0] EDGE_MAX = 5'h1f;
  localparam logic [4:0] CONV_CLKS = 5'h0e;
  localparam int RES_W = 10;
  localparam int FIFO_DEPTH = 16;
  localparam int LVL_W = 5;

  function automatic logic is_conv(input logic [3:0] cmd);
    is_conv = (cmd <= CMD_CH_LAST) ||
      (cmd >= CMD_TEST_LO && cmd <= CMD_TEST_HI);
  endfunction : is_conv

  function automatic logic [4:0] thr_level(input logic [1:0] code);
    unique case (code)
      2'b00: thr_level = 5'h07;
      2'b01: thr_level = 5'h05;
      2'b10: thr_level = 5'h03;
      2'b11: thr_level = 5'h01;
    endcase
  endfunction : thr_level

  function automatic logic [2:0] seq_ch(input logic [1:0] sel,
                                        input logic [2:0] idx);
    unique case (sel)
      2'b00: seq_ch = idx;
      2'b01: seq_ch = {idx[1:0], 1'b0};
      2'b10: seq_ch = {idx[2:1], 1'b0};
      2'b11: seq_ch = {1'b0, idx[0], 1'b0};
    endcase
  endfunction : seq_ch
endpackage : acs_pkg

/* File: src/acs_top.sv */
// acs_top: conversion sequencer with its result fifo
// assumes serial pins come from another domain; result is core-clocked
`timescale 1ns/1ps

module acs_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [$clog2(DEPTH):0] level_out
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg, rd_reg;
  logic [AW:0] cnt_reg;
  logic do_wr, do_rd;

  assign in_ready_out = (cnt_reg != FULL);
  assign out_valid_out = (cnt_reg != '0);
  assign out_data_out = mem[rd_reg];
  assign level_out = cnt_reg;
  // flush wins over a write in the same cycle
  assign do_wr = in_valid_in & in_ready_out & ~flush_in;
  assign do_rd = out_valid_out & out_ready_in & ~flush_in;

  always_ff @(posedge clk_in) begin
    if (ce_in && do_wr) begin
      mem[wr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else if (ce_in) begin
      if (flush_in) begin
        wr_reg <= '0;
        rd_reg <= '0;
        cnt_reg <= '0;
      end else begin
        wr_reg <= wr_reg + AW'(do_wr);
        rd_reg <= rd_reg + AW'(do_rd);
        cnt_reg <= cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
    end
  end
endmodule : acs_fifo

module acs_top
  import acs_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic CE_IN,
  input wire logic SCLK_IN,
  input wire logic CS_N_IN,
  input wire logic FRAME_SYNC_IN,
  input wire logic SDI_IN,
  input wire logic SAMPLE_START_N_IN,
  input wire logic [RES_W-1:0] ADC_RESULT_IN,
  output logic SERIAL_DATA_OUT,
  output logic SERIAL_DATA_OE_N_OUT,
  output logic STATUS_N_OUT,
  output logic SAMPLING_OUT,
  output logic CONVERTING_OUT,
  output logic [3:0] CHANNEL_OUT,
  output logic [LVL_W-1:0] FIFO_LEVEL_OUT
);
  // pin order in the synchroniser vectors
  localparam int P_SCLK = 4, P_CS = 3, P_FS = 2, P_SDI = 1, P_ST = 0;

  logic [4:0] meta_reg, sync_reg, prev_reg, edge_reg, conv_cnt_reg;
  acs_state_t st_reg, st_next;
  logic ext_reg, in_frame_reg, sweep_done_reg, irq_n_reg, irq_pend_reg;
  logic oe_n_reg, status_reg, samp_reg, busy_reg;
  logic [15:0] in_sr_reg, out_sr_reg;
  logic [11:0] cfg_reg;
  logic [RES_W-1:0] result_reg, fifo_head;
  logic [2:0] idx_reg;
  logic [3:0] chan_reg, cmd_w, chan_next;
  logic [LVL_W-1:0] lvl_reg, fifo_lvl;

  logic sclk_rise, sclk_fall, cs_n_s, cs_fall, cs_rise, fs_rise, sdi_s;
  logic start_fall, start_rise, frame_start, cmd_dec, cfg_wr, sweep_m;
  logic conv_ok, norm_go, ext_go, go, samp_end, conv_done, push, hit;
  logic pop, flush, fifo_in_ready, fifo_out_valid;
  logic [4:0] edge_next, win_end, conv_last;
  acs_mode_t mode;

  // serial pins arrive asynchronously: two stages before any use
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      meta_reg <= 5'h1b;
      sync_reg <= 5'h1b;
      prev_reg <= 5'h1b;
    end else if (CE_IN) begin
      meta_reg <= {SCLK_IN, CS_N_IN, FRAME_SYNC_IN, SDI_IN,
                   SAMPLE_START_N_IN};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign sclk_rise = sync_reg[P_SCLK] & ~prev_reg[P_SCLK];
  assign sclk_fall = ~sync_reg[P_SCLK] & prev_reg[P_SCLK];
  assign cs_n_s = sync_reg[P_CS];
  assign cs_fall = ~sync_reg[P_CS] & prev_reg[P_CS];
  assign cs_rise = sync_reg[P_CS] & ~prev_reg[P_CS];
  assign fs_rise = sync_reg[P_FS] & ~prev_reg[P_FS];
  assign sdi_s = sync_reg[P_SDI];
  assign start_fall = ~sync_reg[P_ST] & prev_reg[P_ST];
  assign start_rise = sync_reg[P_ST] & ~prev_reg[P_ST];
  // frame sync may frame commands with chip select held low
  assign frame_start = cs_fall | (fs_rise & ~cs_n_s);
  assign edge_next = edge_reg + 5'h01;
  assign cmd_dec = sclk_rise & in_frame_reg & (edge_next == CMD_EDGE);
  assign cmd_w = {in_sr_reg[2:0], sdi_s};
  assign cfg_wr = sclk_rise & in_frame_reg &
    (edge_next == FRAME_EDGE) & (in_sr_reg[14:11] == CMD_WR_CFG);

  assign mode = acs_mode_t'(cfg_reg[CFG_MODE_LO +: 2]);
  assign sweep_m = cfg_reg[CFG_MODE_LO + 1];
  // a full fifo stalls new triggers; a finished sweep waits for service
  assign conv_ok = (mode == MODE_ONE || fifo_in_ready) &&
    !(mode == MODE_SWP && sweep_done_reg);
  assign norm_go = cmd_dec & is_conv(cmd_w) & conv_ok;
  assign ext_go = start_fall & cs_n_s & conv_ok;
  assign go = norm_go | ext_go;
  assign win_end = cfg_reg[CFG_LONG] ? LONG_EDGE : SHORT_EDGE;
  assign samp_end = (st_reg == ACS_SAMPLE) && (ext_reg ?
    (start_rise & cs_n_s) :
    (sclk_rise & (edge_next == win_end)));
  assign conv_last = (cfg_reg[CFG_DIV] ? {CONV_CLKS[3:0], 1'b0} :
    CONV_CLKS) - 5'h01;
  assign conv_done = (st_reg == ACS_CONV) && (conv_cnt_reg == conv_last)
    && !go;
  assign push = conv_done & (mode != MODE_ONE);
  assign hit = push & (fifo_lvl + 5'h01 ==
    thr_level(cfg_reg[CFG_THR_LO +: 2]));
  assign pop = cmd_dec & (cmd_w == CMD_FIFO_RD) & fifo_out_valid;
  // configure, skipped read, or start pin restart in repeat-sweep mode with an interrupt pending empties the fifo
  assign flush = cfg_wr |
    (cmd_dec & irq_pend_reg & (cmd_w != CMD_FIFO_RD)) |
    (ext_go & irq_pend_reg & (mode == MODE_RSW));
  assign chan_next = sweep_m ?
    {1'b0, seq_ch(cfg_reg[CFG_SEQ_LO +: 2], idx_reg)} :
    (norm_go ? cmd_w : chan_reg);

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      ACS_IDLE: if (go) st_next = ACS_SAMPLE;
      ACS_SAMPLE: if (samp_end) st_next = ACS_CONV;
      ACS_CONV: begin
        if (go) begin
          st_next = ACS_SAMPLE;
        end else if (conv_done) begin
          st_next = ACS_IDLE;
        end
      end
      default: st_next = ACS_IDLE;
    endcase
  end

  acs_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .ce_in(CE_IN),
    .flush_in(flush),
    .in_valid_in(push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(ADC_RESULT_IN),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(pop),
    .out_data_out(fifo_head),
    .level_out(fifo_lvl)
  );

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      st_reg <= ACS_IDLE;
      ext_reg <= 1'b0;
      conv_cnt_reg <= 5'h00;
      chan_reg <= 4'h0;
    end else if (CE_IN) begin
      st_reg <= st_next;
      if (go) begin
        ext_reg <= ext_go;
        chan_reg <= chan_next;
      end
      conv_cnt_reg <= (st_reg == ACS_CONV && !go) ?
        conv_cnt_reg + 5'h01 : 5'h00;
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      in_frame_reg <= 1'b0;
      edge_reg <= 5'h00;
      in_sr_reg <= 16'h0000;
      cfg_reg <= CFG_RST;
    end else if (CE_IN) begin
      if (frame_start) begin
        in_frame_reg <= 1'b1;
      end else if (cs_rise) begin
        in_frame_reg <= 1'b0;
      end
      if (frame_start) begin
        edge_reg <= 5'h00;
      end else if (sclk_rise && edge_reg != EDGE_MAX) begin
        edge_reg <= edge_next;
      end
      if (sclk_rise && in_frame_reg && edge_reg < FRAME_EDGE) begin
        in_sr_reg <= {in_sr_reg[14:0], sdi_s};
      end
      if (cfg_wr) begin
        cfg_reg <= {in_sr_reg[10:0], sdi_s};
      end
    end
  end

  // output word: held result or fifo head at frame start, config on read
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      out_sr_reg <= 16'h0000;
      result_reg <= '0;
      oe_n_reg <= 1'b1;
    end else if (CE_IN) begin
      if (frame_start) begin
        out_sr_reg <= {(mode == MODE_ONE) ? result_reg :
          (fifo_out_valid ? fifo_head : {RES_W{1'b0}}), 6'h00};
      end else if (cmd_dec && cmd_w == CMD_RD_CFG) begin
        out_sr_reg <= {cfg_reg, 4'h0};
      end else if (sclk_fall && in_frame_reg) begin
        out_sr_reg <= {out_sr_reg[14:0], 1'b0};
      end
      if (conv_done && mode == MODE_ONE) begin
        result_reg <= ADC_RESULT_IN;
      end
      oe_n_reg <= cs_n_s;
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      idx_reg <= 3'h0;
      sweep_done_reg <= 1'b0;
      irq_n_reg <= 1'b1;
      irq_pend_reg <= 1'b0;
    end else if (CE_IN) begin
      if (cfg_wr) begin
        idx_reg <= 3'h0;
      end else if (push && sweep_m) begin
        idx_reg <= idx_reg + 3'h1;
      end
      if (push && mode == MODE_SWP && (hit || idx_reg == 3'h7)) begin
        sweep_done_reg <= 1'b1;
      end else if (cfg_wr || (cmd_dec && cmd_w == CMD_FIFO_RD)) begin
        sweep_done_reg <= 1'b0;
      end
      // set wins over the frame that services the interrupt
      if (hit || (conv_done && mode == MODE_ONE)) begin
        irq_n_reg <= 1'b0;
      end else if (frame_start) begin
        irq_n_reg <= 1'b1;
      end
      if (hit) begin
        irq_pend_reg <= 1'b1;
      end else if (cmd_dec || cfg_wr) begin
        irq_pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      status_reg <= 1'b1;
      samp_reg <= 1'b0;
      busy_reg <= 1'b0;
      lvl_reg <= '0;
    end else if (CE_IN) begin
      status_reg <= (mode == MODE_ONE && cfg_reg[CFG_PIN]) ?
        (st_reg != ACS_CONV) : irq_n_reg;
      samp_reg <= (st_reg == ACS_SAMPLE);
      busy_reg <= (st_reg == ACS_CONV);
      lvl_reg <= fifo_lvl;
    end
  end

  assign SERIAL_DATA_OUT = out_sr_reg[15];
  assign SERIAL_DATA_OE_N_OUT = oe_n_reg;
  assign STATUS_N_OUT = status_reg;
  assign SAMPLING_OUT = samp_reg;
  assign CONVERTING_OUT = busy_reg;
  assign CHANNEL_OUT = chan_reg;
  assign FIFO_LEVEL_OUT = lvl_reg;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN || !CE_IN);

  sequence s_conv_begin;
    st_reg == ACS_CONV ##1 CONVERTING_OUT;
  endsequence

  chk_cmd_sample: assert property (
    $rose(st_reg == ACS_SAMPLE) && !ext_reg |-> edge_reg == CMD_EDGE)
    else $error("normal sampling began off the fourth edge");
  chk_norm_window: assert property (
    st_reg == ACS_SAMPLE && !ext_reg && !go && sclk_rise &&
    edge_next == (cfg_reg[CFG_LONG] ? 5'h1c : 5'h10) |=> s_conv_begin)
    else $error("conversion did not start at window end");
  chk_ext_close: assert property (
    st_reg == ACS_SAMPLE && ext_reg && !go && start_rise && cs_n_s
    |=> s_conv_begin)
    else $error("start pin rise did not begin conversion");
  chk_start_ignored: assert property (
    start_fall && !cs_n_s && !norm_go && st_reg == ACS_IDLE
    |=> st_reg == ACS_IDLE)
    else $error("start pin acted while chip select low");
  chk_eoc_busy: assert property (
    mode == MODE_ONE && cfg_reg[CFG_PIN] && st_reg == ACS_CONV
    |=> !STATUS_N_OUT)
    else $error("eoc not low during one-shot conversion");
  chk_irq_only: assert property (
    mode != MODE_ONE |=> STATUS_N_OUT == $past(irq_n_reg))
    else $error("status pin not irq outside one-shot");
  chk_thresh_irq: assert property (
    hit |=> !irq_n_reg ##1 !STATUS_N_OUT || mode == MODE_ONE)
    else $error("threshold did not raise the interrupt");
  chk_one_result: assert property (
    conv_done && mode == MODE_ONE |=>
    result_reg == $past(ADC_RESULT_IN) && fifo_lvl == $past(fifo_lvl))
    else $error("one-shot result not held or fifo touched");
  chk_flush_unread: assert property (
    cmd_dec && irq_pend_reg && cmd_w != CMD_FIFO_RD |=> fifo_lvl == 5'h00)
    else $error("unread fifo not discarded");
  chk_read_keeps: assert property (
    pop && !push |=> fifo_lvl == $past(fifo_lvl) - 5'h01)
    else $error("fifo read lost stored results");
  chk_sweep_stop: assert property (
    mode == MODE_SWP && sweep_done_reg && st_reg == ACS_IDLE &&
    !cfg_wr |=> st_reg == ACS_IDLE)
    else $error("sweep continued after it finished");
endmodule : acs_top

/* File: sim/acs_host.sv */
// acs_host: behavioural serial host and start pin driver for the sequencer
// assumes a 40 ns core clock; the 320 ns link clock runs only in frames
`timescale 1ns/1ps

module acs_host (
  input wire logic clk_in,
  input wire logic sdo_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic fs_out,
  output logic sdi_out,
  output logic start_n_out
);
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    fs_out = 1'b0;
    sdi_out = 1'b0;
    start_n_out = 1'b1;
  end

  // pins change just after a core clock edge, always by the same delay
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick

  task automatic hold_cs(input logic v);
    tick(1);
    cs_n_out = v;
    tick(4);
  endtask : hold_cs

  // frame of n link clocks; output bit taken just before each of the first 16 falls
  task automatic frame(input logic [15:0] word, input int n,
                       input logic use_fs, output logic [15:0] rd);
    rd = 16'h0000;
    hold_cs(1'b0);
    if (use_fs) begin
      fs_out = 1'b1;
      tick(4);
      fs_out = 1'b0;
      tick(4);
    end
    for (int i = 0; i < n; i++) begin
      if (i < 16) begin
        rd = {rd[14:0], sdo_in};
      end
      sclk_out = 1'b0;
      // past the command word the data line toggles every clock
      sdi_out = (i < 16) ? word[15 - i] : ~sdi_out;
      tick(4);
      sclk_out = 1'b1;
      tick(4);
    end
    sdi_out = ~sdi_out;
    hold_cs(1'b1);
  endtask : frame

  // extended sample window: start pin low for a number of core clocks
  task automatic ext(input int cycles);
    tick(1);
    start_n_out = 1'b0;
    tick(cycles);
    start_n_out = 1'b1;
  endtask : ext
endmodule : acs_host

/* File: sim/adc_conversion_sequencer_test.sv */
// adc_conversion_sequencer_test: self-checking bench of the sequencer
// assumes acs_host drives the serial pins; the analog result is ideal
`timescale 1ns/1ps

module adc_conversion_sequencer_test;
  typedef struct {
    logic [11:0] cfg;
    logic [3:0] cmd;
    int n;
    logic fs;
    logic [9:0] adc;
    int samp;
  } acs_row_t;
  logic clk_in, arst_n_in, sclk, cs_n, fs, sdi, start_n, serial_data_out, oe_n;
  logic status_n, sampling, converting;
  logic [3:0] channel, chan;
  logic [4:0] level;
  logic [9:0] adc;
  logic [15:0] rd;
  logic stat_q = 1'b1;
  int n_errors, tests_run, cyc, s_cnt, c_cnt, e_cnt, k;
  int samp_len, conv_len, st_len, n_done, n_samp, n_fall;
  int lvl[4] = '{7, 5, 3, 1};
  int seqx[3][4] = '{'{0, 2, 4, 6}, '{0, 0, 2, 2}, '{0, 2, 0, 2}};
  acs_row_t rows[5] = '{
    '{12'h000, 4'h0, 16, 1'b0, 10'h2a5, 96},
    '{12'h000, 4'h7, 16, 1'b1, 10'h15a, 96},
    '{12'h000, 4'hb, 16, 1'b0, 10'h3ff, 96},
    '{12'h200, 4'h3, 28, 1'b1, 10'h001, 192},
    '{12'h200, 4'hd, 28, 1'b0, 10'h200, 192}
  };

  acs_top dut (.CLK_IN(clk_in), .ARST_N_IN(arst_n_in), .CE_IN(1'b1),
    .SCLK_IN(sclk), .CS_N_IN(cs_n), .FRAME_SYNC_IN(fs), .SDI_IN(sdi),
    .SAMPLE_START_N_IN(start_n), .ADC_RESULT_IN(adc),
    .SERIAL_DATA_OUT(serial_data_out), .SERIAL_DATA_OE_N_OUT(oe_n),
    .STATUS_N_OUT(status_n), .SAMPLING_OUT(sampling),
    .CONVERTING_OUT(converting), .CHANNEL_OUT(channel),
    .FIFO_LEVEL_OUT(level));
  acs_host host (.clk_in(clk_in), .sdo_in(serial_data_out), .sclk_out(sclk),
    .cs_n_out(cs_n), .fs_out(fs), .sdi_out(sdi), .start_n_out(start_n));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic stop_test;
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic chk_eq(input logic [15:0] got, input logic [15:0] exp,
                        input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask : chk_eq

  task automatic chk_rng(input int got, input int lo, input int hi,
                         input string what);
    tests_run++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("wrong value at %0t: %s %0d", $time, what, got);
    end
  endtask : chk_rng

  // window, busy and status lengths and event counts seen at the pins
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    s_cnt <= sampling ? s_cnt + 1 : 0;
    c_cnt <= converting ? c_cnt + 1 : 0;
    e_cnt <= !status_n ? e_cnt + 1 : 0;
    stat_q <= status_n;
    if (sampling && s_cnt == 0) n_samp <= n_samp + 1;
    if (!sampling && s_cnt != 0) samp_len <= s_cnt;
    if (converting && c_cnt == 0) chan <= channel;
    if (!converting && c_cnt != 0) begin
      conv_len <= c_cnt;
      n_done <= n_done + 1;
    end
    if (status_n && e_cnt != 0) st_len <= e_cnt;
    if (stat_q && status_n === 1'b0) n_fall <= n_fall + 1;
    if (cyc == 60000) begin
      n_errors++;
      stop_test();
    end
  end

  // n == 0 uses the start pin; waits for the conversion end, bounded
  task automatic trig(input logic [3:0] cmd, input int n, input logic fs,
                      input logic exp_conv);
    int b, s, w;
    b = n_done;
    s = n_samp;
    w = 0;
    if (n == 0) host.ext(25);
    else host.frame({cmd, 12'h000}, n, fs, rd);
    while (n_done == b && w < 200) begin
      @(posedge clk_in);
      w++;
    end
    repeat (4) @(posedge clk_in);
    #1;
    chk_eq(16'(n_done != b), 16'(exp_conv), "conversion");
    if (!exp_conv) chk_eq(16'(n_samp != s), 16'h0000, "sampling");
  endtask : trig

  task automatic cfg_wr(input logic [11:0] cfg);
    host.frame({4'ha, cfg}, 16, 1'b0, rd);
  endtask : cfg_wr

  task automatic read_fifo(input int cnt, input logic [9:0] base);
    for (int j = 0; j < cnt; j++) begin
      host.frame(16'he000, 16, 1'b0, rd);
      chk_eq(rd, {base + 10'(j), 6'h00}, "fifo data");
    end
  endtask : read_fifo

  initial begin
    arst_n_in = 1'b0;
    adc = 10'h000;
    repeat (10) @(posedge clk_in);
    #1;
    chk_eq({2'b00, serial_data_out, oe_n, status_n, sampling, converting, channel,
      level}, 16'h1800, "reset state");
    arst_n_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    chk_eq({2'b00, serial_data_out, oe_n, status_n, sampling, converting, channel,
      level}, 16'h1800, "after reset");
    foreach (rows[i]) begin
      cfg_wr(rows[i].cfg);
      adc = rows[i].adc;
      k = n_fall;
      trig(rows[i].cmd, rows[i].n, rows[i].fs, 1'b1);
      chk_eq(16'(chan), 16'(rows[i].cmd), "channel");
      chk_rng(samp_len, rows[i].samp - 6, rows[i].samp + 6, "window");
      chk_rng(conv_len, 13, 15, "busy time");
      chk_eq(16'(status_n), 16'h0000, "one-shot int");
      chk_eq(16'(n_fall - k), 16'h0001, "end marks");
      host.frame(16'he000, 16, 1'b0, rd);
      chk_eq(rd, {rows[i].adc, 6'h00}, "held result");
    end
    trig(4'h9, 16, 1'b0, 1'b0);
    chk_eq(16'(rd[11:0]), 16'h0200, "config read");
    trig(4'he, 16, 1'b0, 1'b0);
    host.hold_cs(1'b0);
    trig(4'h0, 0, 1'b0, 1'b0);
    host.hold_cs(1'b1);
    trig(4'h0, 0, 1'b0, 1'b1);
    chk_rng(samp_len, 21, 29, "extended window");
    cfg_wr(12'h004);
    trig(4'h0, 0, 1'b0, 1'b1);
    chk_rng(st_len, conv_len - 2, conv_len + 2, "eoc low");
    chk_eq(16'(status_n), 16'h0001, "eoc released");
    for (int c = 0; c < 4; c++) begin
      cfg_wr(12'h024 | 12'(c));
      k = n_fall;
      adc = 10'h100;
      trig(4'h5, 16, 1'b0, 1'b1);
      for (int m = 1; m < 8 && status_n !== 1'b0; m++) begin
        adc = 10'h100 + 10'(m);
        trig(4'h0, 0, 1'b0, 1'b1);
      end
      chk_eq(16'(level), 16'(lvl[c]), "threshold level");
      chk_eq(16'(n_fall - k), 16'h0001, "single int");
      read_fifo(lvl[c], 10'h100);
      chk_eq(16'(level), 16'h0000, "fifo emptied");
      trig(4'h0, 0, 1'b0, 1'b1);
      chk_eq(16'(chan), 16'h0005, "same channel");
    end
    trig(4'h2, 16, 1'b0, 1'b1);
    chk_eq(16'(level), 16'h0001, "unread fifo flushed");
    cfg_wr(12'h045);
    for (int m = 0; m < 5; m++) begin
      adc = 10'h200 + 10'(m);
      trig(4'h0, 0, 1'b0, 1'b1);
      chk_eq(16'(chan), 16'(m), "sweep channel");
    end
    chk_eq(16'(status_n), 16'h0000, "sweep int");
    trig(4'h0, 0, 1'b0, 1'b0);
    read_fifo(5, 10'h200);
    trig(4'h0, 0, 1'b0, 1'b1);
    cfg_wr(12'h063);
    adc = 10'h0aa;
    trig(4'h0, 0, 1'b0, 1'b1);
    chk_eq({11'h000, status_n, level[3:0]}, 16'h0001, "repeat int");
    adc = 10'h155;
    trig(4'h0, 0, 1'b0, 1'b1);
    chk_eq(16'(level), 16'h0001, "flushed before store");
    chk_eq(16'(chan), 16'h0001, "sweep continued");
    read_fifo(1, 10'h155);
    for (int s = 1; s < 4; s++) begin
      cfg_wr(12'h063 | 12'(s << 3));
      for (int m = 0; m < 4; m++) begin
        trig(4'h0, 0, 1'b0, 1'b1);
        chk_eq(16'(chan), 16'(seqx[s-1][m]), "sweep order");
      end
    end
    cfg_wr(12'h100);
    trig(4'h0, 0, 1'b0, 1'b1);
    chk_rng(conv_len, 27, 29, "halved clock busy");
    stop_test();
  end
endmodule : adc_conversion_sequencer_test
